// ==== src/adc_input_mux_sequencer.sv ====
// input multiplexer sequencer with configuration registers and result fifo
//
// Contract
// RQ1 - eight current inputs, single-ended each or grouped as four adjacent differential pairs; only pair zero can pair here.
// RQ2 - pair zero differential or two single-ended per its control bit.
// RQ3 - preamp bit set routes pair zero through gain eight, else unity gain.
// RQ4 - remote enable bits turn pairs one to three into digital remote links.
// RQ5 - with remote bits clear, pairs one to three are local analog mux inputs.
// RQ6 - pair zero can never become a remote link.
// RQ7 - remote channel exchanges a bidirectional digital stream with its sensor.
// RQ8 - eleven 4-bit slot fields set conversion order; one pass is a frame.
// RQ9 - slots per frame come from the 4-bit frame-length field.
// RQ10 - each frame starts at slot 0 and runs frame-length conversions.
// RQ11 - up to eleven signals single-ended, seven when all pairs differential.
// RQ12 - software should prefer differential pairing; single-ended stays legal.
// RQ13 - software holds frame length zero while configuring, then sets slots.
// RQ14 - unused slots must still carry a channel code from 0 to A.
// RQ15 - after the last slot the next frame starts at slot 0 without gap.

module fifo_buf #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 8
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0] wr_ptr;
	logic [AW-1:0] rd_ptr;
	logic [AW:0] count;
	logic push;
	logic pop;

	assign in_ready = (count != (AW+1)'(DEPTH));
	assign out_valid = (count != '0);
	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;
	assign out_data = mem[rd_ptr];

	always_ff @(posedge clk) begin
		if (push) begin
			mem[wr_ptr] <= in_data;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			count <= '0;
		end else begin
			if (push) begin
				wr_ptr <= (wr_ptr == AW'(DEPTH-1)) ? '0 : wr_ptr + 1'b1;
			end
			if (pop) begin
				rd_ptr <= (rd_ptr == AW'(DEPTH-1)) ? '0 : rd_ptr + 1'b1;
			end
			count <= count + (AW+1)'(push) - (AW+1)'(pop);
		end
	end
endmodule // fifo_buf

////////////////////////////////////////////////////////////////////////////////

module adc_input_mux_sequencer
	import mux_seq_pkg::*;
#(
	parameter int CONV_LEN = CONV_CYCLES
) (
	input wire logic CORE_CLK,
	input wire logic SYS_RST,
	input wire logic [15:0] ADDR,
	input wire logic [7:0] WDATA,
	input wire logic WR,
	input wire logic RD,
	output logic [7:0] RDATA,
	output logic [3:0] MUX_CHANNEL,
	output logic [3:0] MUX_SLOT,
	output logic MUX_ACTIVE,
	output logic [3:0] PAIR_ZERO_GAIN,
	output logic [NUM_CURRENT-1:0] INPUT_DIFF,
	output logic [NUM_REMOTE-1:0] REMOTE_LINK_EN,
	output logic CONV_START,
	input wire logic CONV_DONE,
	input wire logic [NUM_REMOTE-1:0] REMOTE_RX,
	output logic [NUM_REMOTE-1:0] REMOTE_TX,
	output logic [NUM_REMOTE-1:0] REMOTE_TX_OE_N,
	output logic TAG_VALID,
	input wire logic TAG_READY,
	output logic [7:0] TAG_DATA
);
	typedef enum logic [1:0] {IDLE, START, CONVERT, WAIT_FIFO} seq_e;

	logic [7:0] frame_len_byte;
	logic [7:0] sel_byte [5];
	logic [7:0] filt_diff;
	logic [7:0] clk_ctrl;
	logic [7:0] preamp;
	logic [7:0] remote;
	logic [3:0] frame_len;
	logic [3:0] slot;
	logic [3:0] next_slot;
	logic [15:0] timer;
	logic [7:0] frame_count;
	logic sel_error;
	seq_e state;
	logic fifo_in_ready;
	logic push;
	logic [NUM_REMOTE-1:0] rx_sample;

	// slot n lives in byte 0x2105 - n/2, low nibble for even slots; slot 10 shares 0x2100
	function automatic logic [3:0] slot_code(input logic [3:0] s);
		logic [7:0] b;
		b = 8'h00;
		if (s == 4'ha) begin
			b = frame_len_byte;
		end else if (s < 4'ha) begin
			b = sel_byte[3'(s >> 1)];
		end
		return s[0] ? b[7:4] : b[3:0];
	endfunction

	function automatic int sel_index(input logic [15:0] a);
		return int'(ADDR_SEL_10 - a);
	endfunction

	assign frame_len = frame_len_byte[FRAME_LEN_LSB +: 4]; // RQ9

	////////////////////////////////////////////////////////////////////////////
	// register writes

	always_ff @(posedge CORE_CLK) begin
		if (SYS_RST) begin
			frame_len_byte <= RESET_BYTE;
			filt_diff <= RESET_BYTE;
			clk_ctrl <= RESET_BYTE;
			preamp <= RESET_BYTE;
			remote <= RESET_BYTE;
			for (int i = 0; i < 5; i++) begin
				sel_byte[i] <= RESET_BYTE;
			end
		end else if (WR) begin
			unique case (ADDR)
				ADDR_FRAME_LEN: frame_len_byte <= WDATA;
				ADDR_SEL_98, ADDR_SEL_76, ADDR_SEL_54, ADDR_SEL_32, ADDR_SEL_10: begin
					sel_byte[sel_index(ADDR)] <= WDATA; // RQ8
				end
				ADDR_FILT_DIFF: filt_diff <= WDATA;
				ADDR_CLK_CTRL: clk_ctrl <= WDATA;
				ADDR_PREAMP: preamp <= WDATA;
				ADDR_REMOTE: remote <= WDATA;
				default: ;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// register reads: one cycle latency, unmapped reads as zero

	always_ff @(posedge CORE_CLK) begin
		if (SYS_RST) begin
			RDATA <= 8'h00;
		end else if (RD) begin
			unique case (ADDR)
				ADDR_FRAME_LEN: RDATA <= frame_len_byte;
				ADDR_SEL_98, ADDR_SEL_76, ADDR_SEL_54, ADDR_SEL_32, ADDR_SEL_10: begin
					RDATA <= sel_byte[sel_index(ADDR)];
				end
				ADDR_FILT_DIFF: RDATA <= filt_diff;
				ADDR_CLK_CTRL: RDATA <= clk_ctrl;
				ADDR_PREAMP: RDATA <= preamp;
				ADDR_REMOTE: RDATA <= remote;
				ADDR_STATUS: RDATA <= {MUX_ACTIVE, sel_error, 2'b00, slot};
				default: RDATA <= 8'h00;
			endcase
		end else begin
			RDATA <= 8'h00;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// front-end routing

	always_ff @(posedge CORE_CLK) begin
		if (SYS_RST) begin
			PAIR_ZERO_GAIN <= UNITY_GAIN;
			INPUT_DIFF <= '0;
			REMOTE_LINK_EN <= '0;
		end else begin
			PAIR_ZERO_GAIN <= preamp[PREAMP_BIT] ? PREAMP_GAIN : UNITY_GAIN; // RQ3
			// pair zero mirrors its differential bit; other pairs single-ended here
			INPUT_DIFF <= {6'b000000, {2{filt_diff[DIFF0_BIT]}}}; // RQ1 RQ2 RQ11
			// pair zero has no remote bit at all, so it stays analog
			REMOTE_LINK_EN <= remote[REMOTE_LSB +: NUM_REMOTE]; // RQ4 RQ5 RQ6
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// remote links: loop sampled receive data back out inverted, driver off when local

	genvar g;
	generate
		for (g = 0; g < NUM_REMOTE; g++) begin : g_remote
			always_ff @(posedge CORE_CLK) begin
				if (SYS_RST) begin
					rx_sample[g] <= 1'b0;
					REMOTE_TX[g] <= 1'b0;
					REMOTE_TX_OE_N[g] <= 1'b1;
				end else begin
					rx_sample[g] <= REMOTE_RX[g]; // RQ7
					REMOTE_TX[g] <= remote[REMOTE_LSB + g] & ~rx_sample[g]; // RQ7
					REMOTE_TX_OE_N[g] <= ~remote[REMOTE_LSB + g]; // RQ4 RQ7
				end
			end
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////////
	// slot sequencer

	assign next_slot = (slot + 4'h1 >= frame_len) ? 4'h0 : slot + 4'h1; // RQ10 RQ15
	assign push = (state == CONVERT) && CONV_DONE && fifo_in_ready;

	always_ff @(posedge CORE_CLK) begin
		if (SYS_RST) begin
			state <= IDLE;
			slot <= 4'h0;
			timer <= '0;
		end else begin
			unique case (state)
				IDLE: begin
					slot <= 4'h0; // RQ10
					if (frame_len != 4'h0) begin // RQ13
						state <= START;
					end
				end
				START: begin
					// a length cleared since the last slot stops here, so no conversion
					// is launched for a slot that no longer belongs to any frame
					if (frame_len == 4'h0) begin // RQ13
						state <= IDLE;
					end else begin
						timer <= 16'(CONV_LEN);
						state <= CONVERT;
					end
				end
				CONVERT: begin
					if (timer != '0) begin
						timer <= timer - 16'h1;
					end
					if (CONV_DONE) begin
						if (!fifo_in_ready) begin
							state <= WAIT_FIFO;
						end else if (frame_len == 4'h0) begin
							state <= IDLE;
						end else begin
							slot <= next_slot; // RQ8 RQ15
							state <= START;
						end
					end
				end
				WAIT_FIFO: begin
					if (fifo_in_ready) begin
						slot <= next_slot;
						state <= (frame_len == 4'h0) ? IDLE : START;
					end
				end
			endcase
		end
	end

	always_ff @(posedge CORE_CLK) begin
		if (SYS_RST) begin
			MUX_CHANNEL <= 4'h0;
			MUX_SLOT <= 4'h0;
			MUX_ACTIVE <= 1'b0;
			CONV_START <= 1'b0;
			sel_error <= 1'b0;
			frame_count <= 8'h00;
		end else begin
			MUX_CHANNEL <= slot_code(slot); // RQ8
			MUX_SLOT <= slot;
			MUX_ACTIVE <= (state != IDLE);
			CONV_START <= (state == START) && (frame_len != 4'h0); // RQ10
			if (state == START && slot_code(slot) > MAX_CHANNEL) begin
				sel_error <= 1'b1; // RQ14
			end else if (WR && ADDR == ADDR_STATUS) begin
				sel_error <= 1'b0;
			end
			if (push && next_slot == 4'h0) begin
				frame_count <= frame_count + 8'h1;
			end
		end
	end

	fifo_buf #(
		.WIDTH(FIFO_WIDTH),
		.DEPTH(FIFO_DEPTH)
	) u_fifo (
		.clk(CORE_CLK),
		.rst(SYS_RST),
		.in_valid(push),
		.in_ready(fifo_in_ready),
		.in_data({slot, MUX_CHANNEL}),
		.out_valid(TAG_VALID),
		.out_ready(TAG_READY),
		.out_data(TAG_DATA)
	);
endmodule // adc_input_mux_sequencer

// ==== src/mux_seq_pkg.sv ====
// package: register map, field positions, channel codes and timing for the input sequencer
package mux_seq_pkg;
	localparam logic [15:0] ADDR_FRAME_LEN = 16'h2100;
	localparam logic [15:0] ADDR_SEL_98 = 16'h2101;
	localparam logic [15:0] ADDR_SEL_76 = 16'h2102;
	localparam logic [15:0] ADDR_SEL_54 = 16'h2103;
	localparam logic [15:0] ADDR_SEL_32 = 16'h2104;
	localparam logic [15:0] ADDR_SEL_10 = 16'h2105;
	localparam logic [15:0] ADDR_FILT_DIFF = 16'h210c;
	localparam logic [15:0] ADDR_CLK_CTRL = 16'h2200;
	localparam logic [15:0] ADDR_PREAMP = 16'h2704;
	localparam logic [15:0] ADDR_REMOTE = 16'h2709;
	localparam logic [15:0] ADDR_STATUS = 16'h2110;
	localparam int FRAME_LEN_LSB = 4;
	localparam int DIFF0_BIT = 4;
	localparam int PREAMP_BIT = 5;
	localparam int REMOTE_LSB = 3;
	localparam int NUM_SLOTS = 11;
	localparam int NUM_CURRENT = 8;
	localparam int NUM_REMOTE = 3;
	localparam logic [3:0] MAX_CHANNEL = 4'ha;
	localparam logic [3:0] PREAMP_GAIN = 4'h8;
	localparam logic [3:0] UNITY_GAIN = 4'h1;
	localparam logic [7:0] RESET_BYTE = 8'h00;
	localparam int CLK_HZ = 25000000;
	localparam int CONV_NS = 1000;
	localparam int CONV_CYCLES = (CONV_NS * (CLK_HZ / 1000000) + 999) / 1000;
	localparam int FIFO_DEPTH = 8;
	localparam int FIFO_WIDTH = 8;
endpackage

// ==== bench/seq_props.sv ====
// checker: sequencer, control outputs and result buffer seen at the top ports
module seq_props
	import mux_seq_pkg::*;
(
	input wire logic CORE_CLK,
	input wire logic SYS_RST,
	input wire logic [15:0] ADDR,
	input wire logic [7:0] WDATA,
	input wire logic WR,
	input wire logic [3:0] MUX_SLOT,
	input wire logic [3:0] PAIR_ZERO_GAIN,
	input wire logic [NUM_CURRENT-1:0] INPUT_DIFF,
	input wire logic [NUM_REMOTE-1:0] REMOTE_LINK_EN,
	input wire logic [NUM_REMOTE-1:0] REMOTE_TX_OE_N,
	input wire logic [NUM_REMOTE-1:0] REMOTE_RX,
	input wire logic [NUM_REMOTE-1:0] REMOTE_TX,
	input wire logic CONV_START,
	input wire logic CONV_DONE,
	input wire logic TAG_VALID,
	input wire logic TAG_READY,
	input wire logic [7:0] TAG_DATA
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [3:0] flen;
	logic [3:0] flen_d;
	logic [3:0] last;
	logic [3:0] nxt;
	logic seen;
	default clocking cb @(posedge CORE_CLK); endclocking
	default disable iff (SYS_RST);
	////////////////////////////////////////////////////////////////////////////////
	always_ff @(posedge CORE_CLK) begin
		if (SYS_RST) flen <= 4'h0;
		else if (WR && ADDR == ADDR_FRAME_LEN) flen <= WDATA[7:4];
		// the sequencer launches a slot on the length as it stood one edge earlier
		flen_d <= flen;
	end
	// a new frame length restarts the order check at slot 0
	always_ff @(posedge CORE_CLK) begin
		if (SYS_RST || (WR && ADDR == ADDR_FRAME_LEN)) seen <= 1'b0;
		else if (CONV_DONE) seen <= 1'b1;
		if (CONV_DONE) last <= MUX_SLOT;
	end
	assign nxt = (last + 4'h1 == flen) ? 4'h0 : last + 4'h1;
	////////////////////////////////////////////////////////////////////////////////
	a_gain_follows_bit: assert property (
		WR && ADDR == ADDR_PREAMP |-> ##2
		PAIR_ZERO_GAIN == ($past(WDATA[5], 2) ? PREAMP_GAIN : UNITY_GAIN))
		else $error("pair zero gain wrong");
	a_diff_follows_bit: assert property (
		WR && ADDR == ADDR_FILT_DIFF |-> ##2 INPUT_DIFF == {6'h00, {2{$past(WDATA[4], 2)}}})
		else $error("differential flags wrong");
	a_remote_follows_bits: assert property (
		WR && ADDR == ADDR_REMOTE |-> ##2 REMOTE_LINK_EN == $past(WDATA[5:3], 2))
		else $error("remote enables wrong");
	a_link_drive_enable: assert property (
		REMOTE_LINK_EN == $past(REMOTE_LINK_EN) |-> REMOTE_TX_OE_N == ~REMOTE_LINK_EN)
		else $error("link drive enable wrong");
	a_start_one_cycle: assert property (CONV_START |=> !CONV_START)
		else $error("conversion start too long");
	a_slot_within_frame: assert property (CONV_START |-> MUX_SLOT < flen_d)
		else $error("slot beyond frame length");
	a_slot_order_wrap: assert property (
		CONV_START |-> MUX_SLOT == (seen ? nxt : 4'h0))
		else $error("slot order wrong");
	a_next_slot_gapless: assert property (
		CONV_DONE && TAG_READY && flen != 4'h0 && !(WR && ADDR == ADDR_FRAME_LEN)
		|-> ##[1:4] CONV_START)
		else $error("gap before next slot");
	a_link_tx_loop: assert property (
		REMOTE_TX == (~REMOTE_TX_OE_N & ~$past(REMOTE_RX, 2)))
		else $error("link transmit wrong");
	a_tag_held_stalled: assert property (
		TAG_VALID && !TAG_READY |=> TAG_VALID && $stable(TAG_DATA))
		else $error("result changed while stalled");
endmodule // seq_props

bind adc_input_mux_sequencer seq_props u_seq_props (.CORE_CLK, .SYS_RST, .ADDR, .WDATA, .WR,
	.MUX_SLOT, .PAIR_ZERO_GAIN, .INPUT_DIFF, .REMOTE_LINK_EN, .REMOTE_TX_OE_N, .CONV_START,
	.REMOTE_RX, .REMOTE_TX,
	.CONV_DONE, .TAG_VALID, .TAG_READY, .TAG_DATA);

// ==== bench/conv_model.sv ====
// partner: shared converter and remote sensor streams beyond the sequencer
module conv_model (
	input wire logic clk,
	input wire logic rst,
	input wire logic slow,
	input wire logic conv_start,
	output logic conv_done,
	output logic [2:0] remote_rx
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [3:0] cnt;
	// conversion ends a fixed time after its start; slow stretches it
	always_ff @(posedge clk) begin
		if (rst) cnt <= 4'h0;
		else if (conv_start) cnt <= slow ? 4'h9 : 4'h2;
		else if (cnt != 4'h0) cnt <= cnt - 4'h1;
	end
	assign conv_done = (cnt == 4'h1);
	// the stream never rests, so a stuck receive path cannot hide
	always_ff @(posedge clk) begin
		if (rst) remote_rx <= 3'h5;
		else remote_rx <= ~remote_rx;
	end
endmodule // conv_model

// ==== bench/tb_top.sv ====
// testbench: registers, front end controls, frame order and result buffer
module tb_top
	import mux_seq_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	logic core_clk = 1'b0;
	logic sys_rst = 1'b1;
	logic [15:0] addr = 16'h0000;
	logic [7:0] wdata = 8'h00;
	logic wr = 1'b0;
	logic rd = 1'b0;
	logic tag_ready = 1'b0;
	logic slow = 1'b0;
	logic conv_start, conv_done, tag_valid;
	logic [2:0] remote_rx, link, oe_n;
	logic [3:0] gain;
	logic [7:0] rdata, diff, tag_data;
	int miscompares = 0;
	int samples_checked = 0;
	always #20 core_clk = ~core_clk;
	adc_input_mux_sequencer #(.CONV_LEN(4)) u_adc_input_mux_sequencer (.CORE_CLK(core_clk),
		.SYS_RST(sys_rst), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata),
		.MUX_CHANNEL(), .MUX_SLOT(), .MUX_ACTIVE(), .PAIR_ZERO_GAIN(gain), .INPUT_DIFF(diff),
		.REMOTE_LINK_EN(link), .CONV_START(conv_start), .CONV_DONE(conv_done),
		.REMOTE_RX(remote_rx), .REMOTE_TX(), .REMOTE_TX_OE_N(oe_n), .TAG_VALID(tag_valid),
		.TAG_READY(tag_ready), .TAG_DATA(tag_data));
	conv_model u_conv_model (.clk(core_clk), .rst(sys_rst), .slow(slow),
		.conv_start(conv_start), .conv_done(conv_done), .remote_rx(remote_rx));
	////////////////////////////////////////////////////////////////////////////////
	task automatic close_out();
		$display("checks %0d mismatches %0d", samples_checked, miscompares);
		if (miscompares == 0 && samples_checked > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask
	task automatic check(input logic [7:0] got, input logic [7:0] exp);
		samples_checked++;
		if (got !== exp) begin
			miscompares++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge core_clk);
	endtask
	// idle gap after each strobe keeps one assignment per signal per step
	task automatic wr_reg(input logic [15:0] a, input logic [7:0] d);
		wr <= 1'b1;
		addr <= a;
		wdata <= d;
		cyc(1);
		wr <= 1'b0;
		cyc(2);
	endtask
	task automatic rd_chk(input logic [15:0] a, input logic [7:0] exp);
		rd <= 1'b1;
		addr <= a;
		cyc(1);
		rd <= 1'b0;
		cyc(1);
		check(rdata, exp);
	endtask
	task automatic pop(output logic [7:0] d);
		int w;
		w = 0;
		cyc(1);
		while (tag_valid !== 1'b1 && w < 100) begin
			cyc(1);
			w++;
		end
		d = tag_data;
		if (w == 100) begin
			miscompares++;
			$display("mismatch at %0t: got %h expected %h", $time, 1'b0, 1'b1);
		end
	endtask
	////////////////////////////////////////////////////////////////////////////////
	task automatic t_regs();
		logic [15:0] a [10];
		a = '{ADDR_FRAME_LEN, ADDR_SEL_98, ADDR_SEL_76, ADDR_SEL_54, ADDR_SEL_32, ADDR_SEL_10,
			ADDR_FILT_DIFF, ADDR_CLK_CTRL, ADDR_PREAMP, ADDR_REMOTE};
		for (int i = 0; i < 10; i++) begin
			rd_chk(a[i], RESET_BYTE);
			wr_reg(a[i], 8'(8'h11 * i));
			rd_chk(a[i], 8'(8'h11 * i));
		end
		wr_reg(16'h2106, 8'hff);
		rd_chk(16'h2106, 8'h00);
	endtask
	task automatic t_ctrl();
		for (int i = 0; i < 2; i++) begin
			wr_reg(ADDR_PREAMP, i ? 8'h20 : 8'hdf);
			check({4'h0, gain}, i ? PREAMP_GAIN : UNITY_GAIN);
			wr_reg(ADDR_FILT_DIFF, i ? 8'h10 : 8'hef);
			check(diff, i ? 8'h03 : 8'h00);
			wr_reg(ADDR_REMOTE, i ? 8'hff : 8'hc7);
			check({2'h0, link, ~oe_n}, i ? 8'h3f : 8'h00);
		end
	endtask
	task automatic t_frame(input logic [3:0] len);
		logic [7:0] t;
		logic [3:0] s;
		tag_ready <= 1'b1;
		wr_reg(ADDR_FRAME_LEN, 8'h00);
		cyc(20);
		wr_reg(ADDR_FRAME_LEN, {len, 4'h0});
		for (int k = 0; k < 5; k++) begin
			wr_reg(16'(ADDR_SEL_10 - k), {4'(9 - 2 * k), 4'(10 - 2 * k)});
		end
		cyc(150);
		pop(t);
		s = t[7:4];
		for (int n = 0; n < 2 * len; n++) begin
			pop(t);
			s = (s + 4'h1 == len) ? 4'h0 : s + 4'h1;
			check(t, {s, MAX_CHANNEL - s});
		end
	endtask
	task automatic t_stall();
		int n;
		wr_reg(ADDR_FRAME_LEN, 8'h00);
		cyc(30);
		tag_ready <= 1'b0;
		slow <= 1'b1;
		// slot 0 gets an illegal code on purpose so the error flag is exercised
		wr_reg(ADDR_SEL_10, 8'hab);
		wr_reg(ADDR_FRAME_LEN, 8'h30);
		cyc(400);
		check({7'h0, tag_valid}, 8'h01);
		rd_chk(ADDR_STATUS, 8'hc2);
		wr_reg(ADDR_FRAME_LEN, 8'h00);
		cyc(40);
		tag_ready <= 1'b1;
		n = 0;
		repeat (30) begin
			cyc(1);
			if (tag_valid === 1'b1) n++;
		end
		check(8'(n), 8'(FIFO_DEPTH));
		rd_chk(ADDR_STATUS, 8'h40);
		wr_reg(ADDR_STATUS, 8'h00);
		rd_chk(ADDR_STATUS, 8'h00);
	endtask
	////////////////////////////////////////////////////////////////////////////////
	initial begin
		cyc(8);
		sys_rst <= 1'b0;
		cyc(1);
		t_regs();
		t_ctrl();
		t_frame(4'h1);
		t_frame(4'hb);
		t_stall();
		close_out();
	end
	initial begin
		#400000;
		miscompares++;
		close_out();
	end
endmodule // tb_top
